// ### src/uxc_top.sv
/*
  uxc_top: digital control of a full/low speed transceiver with automatic
  charger detection. Assumes pins arrive asynchronous to clk_sys and the
  register port is driven synchronously by the management interface.
*/
`timescale 1ns/1ps
// Behaviour
// - link_speed_select 1 selects full speed, 0 selects low speed.
// - controller interface is 3-pin, 4-pin, 5-pin or not used.
// - not used keeps transceiver off, bus lines released, pull-up off.
// - enable comes from transceiver_enable_field and sleep_keep_alive together.
// - auto detect enabled holds transceiver off until detection completes.
// - after supply good, wait 900 ms then check D- for 100 ms.
// - done flag reads 1 when finished, else 0.
// - outcome 1 means dedicated charger, 0 means USB host.
// - 3-pin transmit maps DATA,SE0 onto D+ and D-.
// - 3-pin receive maps D+,D- onto DATA and SE0.
// - 4 and 5-pin modes present recovered data on receive_data_out.
// - 4/5-pin lines copy to bus when transmitting, bus to lines receiving.
// - 5-pin suspend powers receiver down; driving still follows output enable.
// - during suspend receive_data_out takes receiver_off_level.
module uxc_top
  import uxc_pkg::*;
#(
  parameter longint unsigned SETTLE_CYCLES = SETTLE_CYC,
  parameter longint unsigned CHECK_CYCLES = CHECK_CYC
) (
  input wire logic clk_sys, // 25 MHz system clock
  input wire logic arst_n, // async reset, active low
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  input wire logic [7:0] reg_addr, // register offset
  input wire logic [7:0] reg_wdata, // write data
  output logic [7:0] reg_rdata, // read data, valid cycle after reg_rd
  input wire logic sleep_active, // PMU is in sleep
  input wire logic charger_enable, // battery charger enabled
  input wire logic charger_input_supply, // supply high enough to charge
  input wire logic dp_in, // D+ level
  output logic dp_out, // D+ drive value
  output logic dp_oe, // D+ driven
  input wire logic dm_in, // D- level
  output logic dm_out, // D- drive value
  output logic dm_oe, // D- driven
  output logic pullup_dp, // pull-up on D+ (full speed)
  output logic pullup_dm, // pull-up on D- (low speed)
  output logic full_speed, // 1 full speed, 0 low speed
  output logic xcvr_on, // transceiver enabled
  input wire logic plus_line_in, // DATA (3-pin) or plus_line level
  output logic plus_line_out, // DATA or plus_line drive value
  output logic plus_line_oe, // device drives plus_line
  input wire logic minus_line_in, // SE0 (3-pin) or minus_line level
  output logic minus_line_out, // SE0 or minus_line drive value
  output logic minus_line_oe, // device drives minus_line
  input wire logic oe_n, // output enable from controller, active low
  input wire logic suspend_ctrl, // 5-pin suspend request
  output logic receive_data_out, // recovered single-ended data
  input wire logic drv_ready, // line driver takes a new state
  output logic tx_accept // transmit buffer has room
);

  logic [7:0] sleep_reg_q;
  logic [7:0] mode_reg_q;
  logic [7:0] speed_reg_q;
  logic [7:0] susp_reg_q;
  logic [PIN_N-1:0] pins_raw;
  logic [PIN_N-1:0] s1_q;
  logic [PIN_N-1:0] s2_q;
  logic [PIN_N-1:0] s3_q;
  logic [PIN_N-1:0] pin_q;
  uxc_det_e det_q;
  logic [CNT_W-1:0] cnt_q;
  logic dm_high_q;
  logic done_q;
  logic result_q;
  logic [1:0] if_mode;
  logic auto_en;
  logic det_run;
  logic on_d;
  logic tx_mode;
  logic suspended;
  logic buf_valid;
  logic [1:0] buf_data;
  logic buf_in_ready;
  logic [1:0] tx_q;
  logic data_prev_q;
  logic [7:0] rdata_d;

  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYCLES - 1);
  localparam logic [CNT_W-1:0] CHECK_LAST = CNT_W'(CHECK_CYCLES - 1);
  localparam logic [PIN_N-1:0] PIN_IDLE = PIN_N'(1) << P_OEN;

  function automatic logic [7:0] reg_next(input logic [7:0] cur, input logic [7:0] off);
    reg_next = (reg_wr && reg_addr == off) ? reg_wdata : cur;
  endfunction : reg_next

  assign if_mode = mode_reg_q[IF_MODE_LSB +: 2];
  assign auto_en = speed_reg_q[AUTO_DETECT_BIT];
  // detection only runs with auto detect set and charger enabled
  assign det_run = auto_en && charger_enable && pin_q[P_VIN];
  assign tx_mode = !pin_q[P_OEN];
  // suspend input only honoured in the 5-pin variant
  assign suspended = (if_mode == IF_5PIN) && pin_q[P_SUSPEND_CTRL];

  // field and sleep permission decide together
  assign on_d = (if_mode != IF_NOT_USED) && mode_reg_q[XCVR_ENABLE_BIT]
             && (!sleep_active || sleep_reg_q[SLEEP_KEEP_ALIVE_BIT])
             && !(auto_en && !done_q);

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sleep_reg_q <= REG_RESET;
      mode_reg_q <= REG_RESET;
      speed_reg_q <= REG_RESET;
      susp_reg_q <= REG_RESET;
    end
    else
    begin
      sleep_reg_q <= reg_next(sleep_reg_q, SLEEP_PERMISSION_CONTROL);
      mode_reg_q <= reg_next(mode_reg_q, TRANSCEIVER_MODE_CONTROL);
      speed_reg_q <= reg_next(speed_reg_q, SPEED_AND_DETECT_CONFIG);
      susp_reg_q <= reg_next(susp_reg_q, RECEIVER_SUSPEND_CONFIG);
    end
  end

  always_comb
  begin
    rdata_d = 8'h00;
    case (reg_addr)
      SLEEP_PERMISSION_CONTROL: rdata_d = sleep_reg_q;
      TRANSCEIVER_MODE_CONTROL: rdata_d = mode_reg_q;
      SPEED_AND_DETECT_CONFIG: rdata_d = speed_reg_q;
      RECEIVER_SUSPEND_CONFIG: rdata_d = susp_reg_q;
      CHARGER_DETECT_STATUS:
      begin
        rdata_d[DETECT_DONE_BIT] = done_q;
        rdata_d[DETECT_RESULT_BIT] = result_q;
      end
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rdata_d;
  end

  // three-stage pin synchroniser; a level is taken once stages two and three agree
  assign pins_raw = {suspend_ctrl, oe_n, minus_line_in, plus_line_in, dm_in, dp_in,
                     charger_input_supply};

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      // oe_n idles high; resetting its stages low would fake a transmit after reset
      s1_q <= PIN_IDLE;
      s2_q <= PIN_IDLE;
      s3_q <= PIN_IDLE;
      pin_q <= PIN_IDLE;
    end
    else
    begin
      s1_q <= pins_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < PIN_N; i++)
      begin
        if (s2_q[i] == s3_q[i])
          pin_q[i] <= s3_q[i];
      end
    end
  end

  // detection sequencer
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      det_q <= DET_IDLE;
      cnt_q <= '0;
      dm_high_q <= 1'b0;
      done_q <= 1'b0;
      result_q <= 1'b0;
    end
    else if (!det_run)
    begin
      // any loss of conditions restarts from the beginning
      // done reads 0 while disabled or supply low
      det_q <= DET_IDLE;
      cnt_q <= '0;
      done_q <= 1'b0;
    end
    else
    begin
      case (det_q)
        DET_IDLE:
        begin
          det_q <= DET_SETTLE;
          cnt_q <= '0;
        end
        DET_SETTLE:
        begin
          // settle wait before looking at the lines
          if (cnt_q == SETTLE_LAST)
          begin
            det_q <= DET_CHECK;
            cnt_q <= '0;
            dm_high_q <= 1'b1;
          end
          else
            cnt_q <= cnt_q + 1'b1;
        end
        DET_CHECK:
        begin
          // line check window; a charger keeps D- high throughout
          dm_high_q <= dm_high_q && pin_q[P_DM];
          if (cnt_q == CHECK_LAST)
          begin
            det_q <= DET_DONE;
            done_q <= 1'b1;
            result_q <= dm_high_q && pin_q[P_DM];
          end
          else
            cnt_q <= cnt_q + 1'b1;
        end
        DET_DONE: det_q <= DET_DONE;
        default: det_q <= DET_IDLE;
      endcase
    end
  end

  // synced controller levels pass a two-entry buffer; levels arriving while it is full in a driver stall are dropped
  uxc_buf2 #(
    .W(2)
  ) u_txbuf (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .in_valid(tx_mode),
    .in_ready(buf_in_ready),
    .in_data({pin_q[P_CA], pin_q[P_CB]}),
    .out_valid(buf_valid),
    .out_ready(drv_ready),
    .out_data(buf_data)
  );

  // room flag registered so the port comes from a flip-flop; it lags the buffer by a cycle
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_q <= 2'b00;
      tx_accept <= 1'b0;
    end
    else
    begin
      tx_accept <= buf_in_ready;
      if (buf_valid && drv_ready)
        tx_q <= buf_data;
    end
  end

  // bus side drive
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      xcvr_on <= 1'b0;
      full_speed <= 1'b0;
      pullup_dp <= 1'b0;
      pullup_dm <= 1'b0;
      dp_out <= 1'b0;
      dm_out <= 1'b0;
      dp_oe <= 1'b0;
      dm_oe <= 1'b0;
    end
    else
    begin
      xcvr_on <= on_d;
      full_speed <= speed_reg_q[LINK_SPEED_BIT];
      // pull-up disconnected whenever the transceiver is off
      pullup_dp <= on_d && speed_reg_q[LINK_SPEED_BIT];
      pullup_dm <= on_d && !speed_reg_q[LINK_SPEED_BIT];
      dp_oe <= on_d && tx_mode;
      dm_oe <= on_d && tx_mode;
      if (if_mode == IF_3PIN)
      begin
        dp_out <= tx_q[1] && !tx_q[0];
        dm_out <= !tx_q[1] && !tx_q[0];
      end
      else
      begin
        dp_out <= tx_q[1];
        dm_out <= tx_q[0];
      end
    end
  end

  // controller side drive
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      plus_line_out <= 1'b0;
      minus_line_out <= 1'b0;
      plus_line_oe <= 1'b0;
      minus_line_oe <= 1'b0;
      data_prev_q <= 1'b0;
    end
    else
    begin
      plus_line_oe <= on_d && !tx_mode;
      minus_line_oe <= on_d && !tx_mode;
      if (if_mode == IF_3PIN)
      begin
        // D+/D- to DATA,SE0; SE0 and both-high keep the last DATA
        minus_line_out <= !pin_q[P_DP] && !pin_q[P_DM];
        if (pin_q[P_DP] != pin_q[P_DM])
        begin
          plus_line_out <= pin_q[P_DP];
          data_prev_q <= pin_q[P_DP];
        end
        else
          plus_line_out <= data_prev_q;
      end
      else
      begin
        // bus lines presented on plus_line/minus_line while receiving
        // line pins stay active in suspend
        plus_line_out <= pin_q[P_DP];
        minus_line_out <= pin_q[P_DM];
      end
    end
  end

  // differential receiver
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      receive_data_out <= 1'b0;
    else if (if_mode == IF_3PIN || !on_d)
      receive_data_out <= 1'b0;
    else if (suspended)
      // receiver powered down, fixed level from register
      receive_data_out <= susp_reg_q[RCV_OFF_LEVEL_BIT];
    else if (pin_q[P_DP] != pin_q[P_DM])
      // recovered data; SE0 and SE1 hold the last bit
      receive_data_out <= pin_q[P_DP];
  end

endmodule : uxc_top

// ### pkg/uxc_pkg.sv
/*
  uxc_pkg: shared constants for the transceiver control and charger detect block.
  Assumes a single 25 MHz system clock and the byte-wide register port of uxc_top.
*/
package uxc_pkg;

  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned SETTLE_MS = 900;
  localparam int unsigned CHECK_MS = 100;
  localparam int unsigned MS_PER_S = 1000;
  localparam longint unsigned SETTLE_CYC = longint'(SETTLE_MS) * CLK_HZ / MS_PER_S;
  localparam longint unsigned CHECK_CYC = longint'(CHECK_MS) * CLK_HZ / MS_PER_S;
  localparam int CNT_W = 25;

  // register offsets
  localparam logic [7:0] SLEEP_PERMISSION_CONTROL = 8'h36;
  localparam logic [7:0] TRANSCEIVER_MODE_CONTROL = 8'h41;
  localparam logic [7:0] SPEED_AND_DETECT_CONFIG = 8'h4d;
  localparam logic [7:0] RECEIVER_SUSPEND_CONFIG = 8'h6b;
  localparam logic [7:0] CHARGER_DETECT_STATUS = 8'h8d;
  localparam logic [7:0] REG_RESET = 8'h00;

  // field positions
  localparam int SLEEP_KEEP_ALIVE_BIT = 0;
  localparam int XCVR_ENABLE_BIT = 0;
  localparam int IF_MODE_LSB = 2;
  localparam int LINK_SPEED_BIT = 0;
  localparam int AUTO_DETECT_BIT = 1;
  localparam int RCV_OFF_LEVEL_BIT = 0;
  localparam int DETECT_DONE_BIT = 0;
  localparam int DETECT_RESULT_BIT = 1;

  // controller-side interface variants
  localparam logic [1:0] IF_NOT_USED = 2'h0;
  localparam logic [1:0] IF_3PIN = 2'h1;
  localparam logic [1:0] IF_4PIN = 2'h2;
  localparam logic [1:0] IF_5PIN = 2'h3;

  // synchronised pin vector layout
  localparam int PIN_N = 7;
  localparam int P_VIN = 0;
  localparam int P_DP = 1;
  localparam int P_DM = 2;
  localparam int P_CA = 3;
  localparam int P_CB = 4;
  localparam int P_OEN = 5;
  localparam int P_SUSPEND_CTRL = 6;

  typedef enum logic [1:0] {
    DET_IDLE = 2'b00,
    DET_SETTLE = 2'b01,
    DET_CHECK = 2'b10,
    DET_DONE = 2'b11
  } uxc_det_e;

endpackage : uxc_pkg

// ### src/uxc_buf2.sv
/*
  uxc_buf2: two-entry valid/ready buffer.
  Assumes source and sink share clk_sys; full and empty are exact.
*/
`timescale 1ns/1ps
module uxc_buf2 #(
  parameter int W = 2
) (
  input wire logic clk_sys, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic in_valid, // source offers a word
  output logic in_ready, // buffer has room
  input wire logic [W-1:0] in_data, // word from source
  output logic out_valid, // word available
  input wire logic out_ready, // sink takes the word
  output logic [W-1:0] out_data // oldest word
);
  logic [W-1:0] mem_q [2];
  logic rd_q;
  logic wr_q;
  logic [1:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end
    else if (push)
    begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      cnt_q <= 2'h0;
    end
    else
    begin
      if (push)
        wr_q <= ~wr_q;
      if (pop)
        rd_q <= ~rd_q;
      if (push && !pop)
        cnt_q <= cnt_q + 2'h1;
      else if (pop && !push)
        cnt_q <= cnt_q - 2'h1;
    end
  end
endmodule : uxc_buf2

// ### sim/uxc_monitor.sv
/*
  uxc_monitor: port-level checks of uxc_top.
  Assumes it is bound to uxc_top and that everything runs on clk_sys.
*/
`timescale 1ns/1ps
module uxc_monitor
  import uxc_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic arst_n, // reset, active low
  input wire logic reg_rd, // read strobe
  input wire logic [7:0] reg_addr, // offset
  input wire logic [7:0] reg_rdata, // read data
  input wire logic dp_oe, // D+ driven
  input wire logic dm_oe, // D- driven
  input wire logic pullup_dp, // D+ pull-up
  input wire logic pullup_dm, // D- pull-up
  input wire logic full_speed, // speed
  input wire logic xcvr_on, // enabled
  input wire logic plus_line_oe, // plus driven
  input wire logic minus_line_oe, // minus driven
  input wire logic receive_data_out // recovered data
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  a_off_released:
    assert property (!xcvr_on && !$past(xcvr_on) |-> !dp_oe && !dm_oe && !pullup_dp && !pullup_dm)
    else $error("bus driven while off");
  a_off_rcv_low:
    assert property (!xcvr_on && !$past(xcvr_on) |-> !receive_data_out)
    else $error("data out while off");
  a_bus_oe_pair:
    assert property (dp_oe == dm_oe)
    else $error("bus enables differ");
  a_ctrl_oe_pair:
    assert property (plus_line_oe == minus_line_oe)
    else $error("line enables differ");
  a_oe_exclusive:
    assert property (!(dp_oe && plus_line_oe))
    else $error("both directions driven");
  a_speed_pullup:
    assert property (xcvr_on && $past(xcvr_on) && $stable(full_speed)
      |-> pullup_dp == full_speed && pullup_dm == !full_speed)
    else $error("pull-up not per speed");
  a_status_upper:
    assert property (reg_rd && reg_addr == CHARGER_DETECT_STATUS |-> ##[1:2] reg_rdata[7:2] == 6'h00)
    else $error("status spare bits set");
  a_rdata_holds:
    assert property (!$past(reg_rd) && !$past(reg_rd, 2) |-> $stable(reg_rdata))
    else $error("read data moved");

  c_status: cover property (reg_rd && reg_addr == CHARGER_DETECT_STATUS);
  c_drive: cover property (dp_oe && xcvr_on);
  c_listen: cover property (plus_line_oe);
  c_full: cover property (full_speed && pullup_dp);
endmodule : uxc_monitor

// ### sim/uxc_partner.sv
/*
  uxc_partner: controller pins and USB far end, resolved against device enables.
  Assumes the testbench sets the wanted levels and the attached far end.
*/
`timescale 1ns/1ps
module uxc_partner (
  input wire logic dp_out, // device D+
  input wire logic dp_oe, // device drives D+
  input wire logic dm_out, // device D-
  input wire logic dm_oe, // device drives D-
  input wire logic plus_line_out, // device plus
  input wire logic plus_line_oe, // device drives plus
  input wire logic minus_line_out, // device minus
  input wire logic minus_line_oe, // device drives minus
  input wire logic ctrl_p, // controller plus
  input wire logic ctrl_m, // controller minus
  input wire logic host_dp, // host D+
  input wire logic host_dm, // host D-
  input wire logic charger_att, // dedicated charger attached
  output logic dp_in, // D+ wire
  output logic dm_in, // D- wire
  output logic plus_line_in, // plus wire
  output logic minus_line_in // minus wire
);
  // a dedicated charger keeps D- high
  assign dp_in = dp_oe ? dp_out : (charger_att ? 1'b0 : host_dp);
  assign dm_in = dm_oe ? dm_out : (charger_att ? 1'b1 : host_dm);
  // controller drives its lines whenever the device leaves them released
  assign plus_line_in = plus_line_oe ? plus_line_out : ctrl_p;
  assign minus_line_in = minus_line_oe ? minus_line_out : ctrl_m;
endmodule : uxc_partner

// ### sim/uxc_top_test.sv
/*
  uxc_top_test: register and pin sequences for uxc_top.
  Assumes short detection counts of 20 and 8 cycles.
*/
`timescale 1ns/1ps
module uxc_top_test
  import uxc_pkg::*;
;
  logic clk_sys, arst_n, reg_wr, reg_rd, sleep_active, charger_enable, charger_input_supply;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic dp_in, dp_out, dp_oe, dm_in, dm_out, dm_oe, pullup_dp, pullup_dm, full_speed, xcvr_on;
  logic plus_line_in, plus_line_out, plus_line_oe, minus_line_in, minus_line_out, minus_line_oe;
  logic oe_n, suspend_ctrl, receive_data_out, drv_ready, tx_accept;
  logic ctrl_p, ctrl_m, host_dp, host_dm, charger_att;
  logic [7:0] offs [6] = '{8'h36, 8'h41, 8'h4d, 8'h6b, 8'h8d, 8'h00};
  logic [0:3] rp = 4'b1000, rm = 4'b0010, ed = 4'b1100, es = 4'b0101;
  int fail_count = 0;
  int check_count = 0;

  uxc_top #(.SETTLE_CYCLES(20), .CHECK_CYCLES(8)) DUT (.clk_sys, .arst_n, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .sleep_active, .charger_enable, .charger_input_supply,
    .dp_in, .dp_out, .dp_oe, .dm_in, .dm_out, .dm_oe, .pullup_dp, .pullup_dm, .full_speed,
    .xcvr_on, .plus_line_in, .plus_line_out, .plus_line_oe, .minus_line_in, .minus_line_out,
    .minus_line_oe, .oe_n, .suspend_ctrl, .receive_data_out, .drv_ready, .tx_accept);
  uxc_partner far (.dp_out, .dp_oe, .dm_out, .dm_oe, .plus_line_out, .plus_line_oe,
    .minus_line_out, .minus_line_oe, .ctrl_p, .ctrl_m, .host_dp, .host_dm, .charger_att,
    .dp_in, .dm_in, .plus_line_in, .minus_line_in);

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic give_verdict();
    if (fail_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc

  task automatic chk1(input logic g, input logic e);
    check_count++;
    if (g !== e)
    begin
      $display("[ERR] %0t bit mismatch", $time);
      fail_count++;
    end
  endtask : chk1

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e)
    begin
      $display("[ERR] %0t byte %h not %h", $time, g, e);
      fail_count++;
    end
  endtask : chk8

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    cyc(1);
    chk8(reg_rdata, e);
  endtask : rd

  // order: ctrl_p, ctrl_m, host_dp, host_dm, oe_n, suspend_ctrl
  task automatic pins(input logic [5:0] v);
    @(posedge clk_sys);
    {ctrl_p, ctrl_m, host_dp, host_dm, oe_n, suspend_ctrl} <= v;
    // a direction flip syncs oe_n first, then the freed line, then buffer and driver
    cyc(14);
  endtask : pins

  initial
  begin
    {arst_n, reg_wr, reg_rd, reg_addr, reg_wdata, sleep_active, charger_enable} = '0;
    {charger_input_supply, ctrl_p, ctrl_m, host_dp, host_dm, suspend_ctrl, charger_att} = '0;
    oe_n = 1'b1;
    drv_ready = 1'b1;
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    foreach (offs[i]) rd(offs[i], 8'h00);
    wr(TRANSCEIVER_MODE_CONTROL, 8'h01);
    cyc(4);
    chk1(xcvr_on, 1'b0);
    wr(CHARGER_DETECT_STATUS, 8'hff);
    rd(CHARGER_DETECT_STATUS, 8'h00);
    wr(TRANSCEIVER_MODE_CONTROL, 8'h05);
    rd(TRANSCEIVER_MODE_CONTROL, 8'h05);
    wr(SPEED_AND_DETECT_CONFIG, 8'h01);
    cyc(4);
    chk1(full_speed, 1'b1);
    chk1(pullup_dp, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      pins({i[1], i[0], 4'b0000});
      chk1(dp_out, i[1] & ~i[0]);
      chk1(dm_out, ~i[1] & ~i[0]);
      chk1(dp_oe, 1'b1);
    end
    for (int i = 0; i < 4; i++)
    begin
      pins({2'b00, rp[i], rm[i], 2'b10});
      chk1(plus_line_out, ed[i]);
      chk1(minus_line_out, es[i]);
    end
    wr(SPEED_AND_DETECT_CONFIG, 8'h00);
    cyc(4);
    chk1(pullup_dm, 1'b1);
    wr(TRANSCEIVER_MODE_CONTROL, 8'h09);
    for (int i = 0; i < 2; i++)
    begin
      pins({2'b00, i[0], ~i[0], 2'b10});
      chk1(receive_data_out, i[0]);
      chk1(minus_line_out, ~i[0]);
    end
    pins(6'b100000);
    chk1(dp_out, 1'b1);
    wr(TRANSCEIVER_MODE_CONTROL, 8'h0d);
    pins(6'b001010);
    chk1(receive_data_out, 1'b1);
    pins(6'b001011);
    chk1(receive_data_out, 1'b0);
    wr(RECEIVER_SUSPEND_CONFIG, 8'h01);
    pins(6'b000111);
    chk1(receive_data_out, 1'b1);
    chk1(plus_line_out, 1'b0);
    @(posedge clk_sys);
    sleep_active <= 1'b1;
    cyc(4);
    chk1(xcvr_on, 1'b0);
    wr(SLEEP_PERMISSION_CONTROL, 8'h01);
    cyc(4);
    chk1(xcvr_on, 1'b1);
    // stall the driver so the queue fills, then let it catch up
    wr(TRANSCEIVER_MODE_CONTROL, 8'h05);
    @(posedge clk_sys);
    drv_ready <= 1'b0;
    pins(6'b100000);
    pins(6'b010000);
    pins(6'b000000);
    chk1(tx_accept, 1'b0);
    @(posedge clk_sys);
    drv_ready <= 1'b1;
    pins(6'b100000);
    chk1(dp_out, 1'b1);
    pins(6'b000010);
    chk1(tx_accept, 1'b1);
    // regulator taken as enabled before the outcome is trusted
    @(posedge clk_sys);
    charger_att <= 1'b1;
    wr(SPEED_AND_DETECT_CONFIG, 8'h03);
    @(posedge clk_sys);
    charger_enable <= 1'b1;
    charger_input_supply <= 1'b1;
    cyc(3);
    chk1(xcvr_on, 1'b0);
    cyc(17);
    rd(CHARGER_DETECT_STATUS, 8'h00);
    cyc(30);
    rd(CHARGER_DETECT_STATUS, 8'h03);
    chk1(xcvr_on, 1'b1);
    @(posedge clk_sys);
    charger_input_supply <= 1'b0;
    charger_att <= 1'b0;
    cyc(8);
    rd(CHARGER_DETECT_STATUS, 8'h02);
    chk1(xcvr_on, 1'b0);
    @(posedge clk_sys);
    charger_input_supply <= 1'b1;
    cyc(50);
    rd(CHARGER_DETECT_STATUS, 8'h01);
    @(posedge clk_sys);
    charger_enable <= 1'b0;
    cyc(4);
    rd(CHARGER_DETECT_STATUS, 8'h00);
    give_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    give_verdict();
  end
endmodule : uxc_top_test

bind uxc_top uxc_monitor mon (.clk_sys, .arst_n, .reg_rd, .reg_addr, .reg_rdata, .dp_oe,
  .dm_oe, .pullup_dp, .pullup_dm, .full_speed, .xcvr_on, .plus_line_oe, .minus_line_oe,
  .receive_data_out);
